// ==== nine_bit_uart_pkg.sv ====
// Constants, types and helpers shared by the nine-bit serial port
package nine_bit_uart_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets on the APB bus
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL = 8'h00; // serial_control_reg
  localparam logic [7:0] OFF_DATA = 8'h04; // serial_data_buffer
  localparam logic [7:0] OFF_STATUS = 8'h08; // serial_status_reg
  localparam logic [7:0] OFF_SLAVE_ADDR = 8'h0C; // Own address
  localparam logic [7:0] OFF_SLAVE_MASK = 8'h10; // Address bit enables

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTL_RX_DONE = 0; // rx_done_flag
  localparam int CTL_TX_DONE = 1; // tx_done_flag
  localparam int CTL_RX_NINTH = 2; // rx_ninth_bit
  localparam int CTL_TX_NINTH = 3; // tx_ninth_bit
  localparam int CTL_RX_ENABLE = 4; // rx_enable_bit
  localparam int CTL_MULTIPROC = 5; // multiproc_mode_bit
  localparam int STA_INT_ENABLE = 0; // Interrupt request enable
  localparam int STA_BAUD_DOUBLE = 4; // baud_double_bit

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SLAVE_ADDR_RESET = 8'h00;
  localparam logic [7:0] SLAVE_MASK_RESET = 8'h00;
  localparam logic [7:0] RX_BUFFER_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Timing: bit time in system clocks, sixteen sample ticks per bit
  // ---------------------------------------------------------------
  localparam int CLKS_PER_BIT_SLOW = 64; // baud_double_bit = 0
  localparam int CLKS_PER_BIT_FAST = 32; // baud_double_bit = 1
  localparam int TICKS_PER_BIT = 16;
  localparam logic [1:0] DIV_SLOW_LAST =
    2'(CLKS_PER_BIT_SLOW / TICKS_PER_BIT - 1);
  localparam logic [1:0] DIV_FAST_LAST =
    2'(CLKS_PER_BIT_FAST / TICKS_PER_BIT - 1);
  localparam logic [3:0] TICK_LAST = 4'(TICKS_PER_BIT - 1);
  localparam logic [3:0] TICK_MID = 4'(TICKS_PER_BIT / 2 - 1);

  // ---------------------------------------------------------------
  // Frame layout: start, 8 data, ninth, stop
  // ---------------------------------------------------------------
  localparam logic [3:0] STOP_INDEX = 4'hA; // Bit slot of the stop bit
  localparam logic [3:0] NINTH_INDEX = 4'h8; // Last data slot counted

  // ---------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {
    TX_IDLE = 1'b0,
    TX_RUN = 1'b1
  } tx_state_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

  // Masked compare of a received byte against the own address
  function automatic logic addr_match(input logic [7:0] rxByte,
                                      input logic [7:0] own,
                                      input logic [7:0] mask);
    addr_match = ((rxByte ^ own) & mask) == 8'h00;
  endfunction

endpackage

// ==== uart_tx_engine.sv ====
// Transmit shifter of the nine-bit serial port
`timescale 1ns/1ps
`default_nettype none

module uart_tx_engine
  import nine_bit_uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick, // Sixteen per bit time
  input wire logic start, // One-cycle start request
  input wire logic [7:0] data, // Byte to send
  input wire logic ninth, // Ninth data bit
  output logic txd, // Serial line, idle high
  output logic busy, // Frame in progress
  output logic done // Pulse at the start of the stop bit
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    tx_state_t state; // Idle or sending
    logic [8:0] frame; // Remaining bits, LSB next
    logic [3:0] bitIdx; // Current bit slot
    logic [3:0] tickCnt; // Ticks inside the slot
    logic line; // Line level
    logic done; // Stop-bit pulse
    logic align; // Waiting for first tick
  } tx_regs_t;

  tx_regs_t s;
  tx_regs_t next_s;

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    unique case (s.state)
      TX_IDLE: begin
        next_s.line = 1'b1;
        // Load and drive the start bit at once
        if (start) begin
          next_s.state = TX_RUN;
          next_s.frame = {ninth, data};
          next_s.bitIdx = 4'h0;
          next_s.tickCnt = 4'h0;
          next_s.line = 1'b0;
          next_s.align = 1'b1;
        end
      end
      TX_RUN: begin
        if (tick) begin
          if (s.align) begin
            next_s.align = 1'b0; // Start bit never short
          end else if (s.tickCnt == TICK_LAST) begin
            next_s.tickCnt = 4'h0;
            if (s.bitIdx == STOP_INDEX) begin
              // Stop bit finished
              next_s.state = TX_IDLE;
              next_s.line = 1'b1;
            end else if (s.bitIdx + 4'h1 == STOP_INDEX) begin
              // Enter the stop bit and flag completion
              next_s.bitIdx = STOP_INDEX;
              next_s.line = 1'b1;
              next_s.done = 1'b1;
            end else begin
              // Next data bit, LSB first
              next_s.bitIdx = s.bitIdx + 4'h1;
              next_s.line = s.frame[0];
              next_s.frame = {1'b0, s.frame[8:1]};
            end
          end else begin
            next_s.tickCnt = s.tickCnt + 4'h1;
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{state: TX_IDLE, frame: 9'h000, bitIdx: 4'h0,
             tickCnt: 4'h0, line: 1'b1, done: 1'b0, align: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign txd = s.line;
  assign busy = (s.state != TX_IDLE);
  assign done = s.done;

endmodule

`default_nettype wire

// ==== uart_rx_engine.sv ====
// Receive sampler of the nine-bit serial port
`timescale 1ns/1ps
`default_nettype none

module uart_rx_engine
  import nine_bit_uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick, // Sixteen per bit time
  input wire logic enable, // Reception allowed
  input wire logic rxd, // Synchronised serial line
  output logic valid, // Pulse: a whole frame arrived
  output logic [7:0] data, // Received byte
  output logic ninth // Received ninth bit
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rx_state_t state; // Frame phase
    logic [3:0] tickCnt; // Ticks inside the bit
    logic [3:0] bitCnt; // Data bits taken
    logic [8:0] shift; // Data and ninth bit
    logic prev; // Line one clock ago
    logic valid; // Frame pulse
  } rx_regs_t;

  rx_regs_t s;
  rx_regs_t next_s;

  // Next-state logic
  always_comb begin
    next_s = s;
    next_s.valid = 1'b0;
    next_s.prev = rxd;
    unique case (s.state)
      RX_IDLE: begin
        // Falling edge opens a frame
        if (enable && s.prev && !rxd) begin
          next_s.state = RX_START;
          next_s.tickCnt = 4'h0;
        end
      end
      RX_START: begin
        if (tick) begin
          if (s.tickCnt == TICK_MID) begin
            // Confirm start bit at mid-bit, else a glitch
            next_s.state = rxd ? RX_IDLE : RX_DATA;
            next_s.tickCnt = 4'h0;
            next_s.bitCnt = 4'h0;
          end else begin
            next_s.tickCnt = s.tickCnt + 4'h1;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          if (s.tickCnt == TICK_LAST) begin
            // Centre of a data bit, LSB arrives first
            next_s.tickCnt = 4'h0;
            next_s.shift = {rxd, s.shift[8:1]};
            if (s.bitCnt == NINTH_INDEX) begin
              next_s.state = RX_STOP;
            end else begin
              next_s.bitCnt = s.bitCnt + 4'h1;
            end
          end else begin
            next_s.tickCnt = s.tickCnt + 4'h1;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          if (s.tickCnt == TICK_LAST) begin
            // Stop bit level is not checked
            next_s.valid = 1'b1;
            next_s.state = RX_IDLE;
          end else begin
            next_s.tickCnt = s.tickCnt + 4'h1;
          end
        end
      end
    endcase
    // Dropping the enable abandons a frame in flight
    if (!enable) begin
      next_s.state = RX_IDLE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{state: RX_IDLE, tickCnt: 4'h0, bitCnt: 4'h0,
             shift: 9'h000, prev: 1'b1, valid: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign valid = s.valid;
  assign data = s.shift[7:0];
  assign ninth = s.shift[8];

endmodule

`default_nettype wire

// ==== nine_bit_uart.sv ====
// Top of the nine-bit fixed-rate serial port with its APB registers
//
// Summary of operation
// - start, 8 data LSB first, ninth, stop
// - transmit and receive run independently
// - ninth transmitted bit comes from tx_ninth_bit
// - received ninth bit to rx_ninth_bit; stop ignored
// - writing the data buffer starts transmission if the shifter is free
// - tx_done_flag set at stop bit start
// - receive only while rx_enable_bit is one
// - accept only while rx_done_flag is zero
// - multiprocessor mode needs ninth one, address match
// - accepted: store byte, ninth bit, set flag
// - rejected: buffer, ninth bit, flag untouched
// - enabled interrupt on either done flag
// - bit rate is clock over 64 or 32
`timescale 1ns/1ps
`default_nettype none

module nine_bit_uart
  import nine_bit_uart_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low

  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,

  // Serial line
  input wire logic rxd, // Receive pin, asynchronous
  output logic txd, // Transmit pin, idle high

  // Processor interrupt
  output logic intReq // Level, active high
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    // Control and status bits
    logic rxEnable; // rx_enable_bit
    logic multiproc; // multiproc_mode_bit
    logic txNinth; // tx_ninth_bit
    logic rxNinth; // rx_ninth_bit
    logic txDone; // tx_done_flag
    logic rxDone; // rx_done_flag
    logic intEnable; // Interrupt request enable
    logic baudDouble; // baud_double_bit

    // Data and address registers
    logic [7:0] rxBuffer; // Last accepted byte
    logic [7:0] slaveAddr; // Own address
    logic [7:0] slaveMask; // Address compare enables

    // Transmit hand-off
    logic [7:0] txData; // Byte handed to transmitter
    logic txStart; // Start pulse to transmitter

    // Divider and synchroniser
    logic [1:0] divCnt; // Sample-tick divider
    logic tick; // Sample tick pulse
    logic rxdMeta; // First synchroniser stage
    logic rxdSync; // Second synchroniser stage

    // Bus answer and interrupt
    logic [31:0] rdata; // Read data to bus
    logic ready; // Access-phase answer
    logic slverr; // Unmapped access
    logic irq; // Interrupt output
  } top_regs_t;

  // State and its next value
  top_regs_t s;
  top_regs_t next_s;

  // Transmitter and receiver hookups
  logic txLine; // Line from shifter
  logic txBusy; // Frame in progress
  logic txStopPulse; // Start of stop bit

  logic rxValid; // Frame received
  logic [7:0] rxByte; // Received byte
  logic rxNinthIn; // Received ninth bit

  // Bus decode helpers
  logic setupPhase; // First cycle of a transfer
  logic writeDone; // Write takes effect now
  logic acceptFrame; // Received frame is kept
  logic known; // Address hits a register

  // ---------------------------------------------------------------
  // Engines
  // ---------------------------------------------------------------

  // Transmit shifter, runs apart from the receiver
  uart_tx_engine txEngine (
    .clk(clk),
    .rst_n(rst_n),
    .tick(s.tick),
    .start(s.txStart),
    .data(s.txData),
    .ninth(s.txNinth),
    .txd(txLine),
    .busy(txBusy),
    .done(txStopPulse)
  );

  // Receive sampler, fed from the synchronised pin
  uart_rx_engine rxEngine (
    .clk(clk),
    .rst_n(rst_n),
    .tick(s.tick),
    .enable(s.rxEnable),
    .rxd(s.rxdSync),
    .valid(rxValid),
    .data(rxByte),
    .ninth(rxNinthIn)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------

  // Phase and address qualification
  always_comb begin
    setupPhase = psel && !penable;
    writeDone = psel && penable && s.ready && pwrite;

    unique case (paddr)
      OFF_CONTROL, OFF_DATA, OFF_STATUS,
      OFF_SLAVE_ADDR, OFF_SLAVE_MASK: known = 1'b1;
      default: known = 1'b0;
    endcase
  end

  // Frame acceptance test
  always_comb begin
    acceptFrame = rxValid && !s.rxDone;

    if (s.multiproc) begin
      // Only address frames aimed at this port
      acceptFrame = acceptFrame && rxNinthIn &&
        addr_match(rxByte, s.slaveAddr, s.slaveMask);
    end
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.txStart = 1'b0;
    next_s.tick = 1'b0;

    // Two-stage synchroniser on the receive pin
    next_s.rxdMeta = rxd;
    next_s.rxdSync = s.rxdMeta;

    // Tick every 4 clocks (div 64) or every 2 (div 32)
    if (s.divCnt == 2'h0) begin
      next_s.tick = 1'b1;
      next_s.divCnt = s.baudDouble ? DIV_FAST_LAST : DIV_SLOW_LAST;
    end else begin
      next_s.divCnt = s.divCnt - 2'h1;
    end

    // Answer one cycle after setup, i.e. in the access phase
    next_s.ready = setupPhase;
    next_s.slverr = setupPhase && !known;

    // Read data latched at setup
    next_s.rdata = 32'h0000_0000;
    if (setupPhase && !pwrite) begin
      unique case (paddr)
        OFF_CONTROL: begin
          next_s.rdata[CTL_RX_DONE] = s.rxDone;
          next_s.rdata[CTL_TX_DONE] = s.txDone;
          next_s.rdata[CTL_RX_NINTH] = s.rxNinth;
          next_s.rdata[CTL_TX_NINTH] = s.txNinth;
          next_s.rdata[CTL_RX_ENABLE] = s.rxEnable;
          next_s.rdata[CTL_MULTIPROC] = s.multiproc;
        end

        OFF_DATA: next_s.rdata[7:0] = s.rxBuffer;
        OFF_STATUS: begin
          next_s.rdata[STA_INT_ENABLE] = s.intEnable;
          next_s.rdata[STA_BAUD_DOUBLE] = s.baudDouble;
        end

        OFF_SLAVE_ADDR: next_s.rdata[7:0] = s.slaveAddr;
        OFF_SLAVE_MASK: next_s.rdata[7:0] = s.slaveMask;
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes at the completing access edge
    if (writeDone) begin
      unique case (paddr)
        OFF_CONTROL: begin
          // Flags take the written value; events below win
          next_s.rxDone = pwdata[CTL_RX_DONE];
          next_s.txDone = pwdata[CTL_TX_DONE];
          next_s.rxNinth = pwdata[CTL_RX_NINTH];
          next_s.txNinth = pwdata[CTL_TX_NINTH];
          next_s.rxEnable = pwdata[CTL_RX_ENABLE];
          next_s.multiproc = pwdata[CTL_MULTIPROC];
        end

        OFF_DATA: begin
          // Byte write launches a frame if the shifter is free
          if (!txBusy && !s.txStart) begin
            next_s.txData = pwdata[7:0];
            next_s.txStart = 1'b1;
          end
        end

        OFF_STATUS: begin
          next_s.intEnable = pwdata[STA_INT_ENABLE];
          next_s.baudDouble = pwdata[STA_BAUD_DOUBLE];
        end

        OFF_SLAVE_ADDR: next_s.slaveAddr = pwdata[7:0];
        OFF_SLAVE_MASK: next_s.slaveMask = pwdata[7:0];
        default: next_s.slaveMask = s.slaveMask;
      endcase
    end

    // Transmit completion, set wins over a clearing write
    // Stop pulse is one cycle long
    if (txStopPulse) begin
      next_s.txDone = 1'b1;
    end

    // Received frame: store only when accepted
    if (acceptFrame) begin
      next_s.rxBuffer = rxByte;
      next_s.rxNinth = rxNinthIn;
      next_s.rxDone = 1'b1;
    end

    // Interrupt follows either done flag when enabled
    next_s.irq = next_s.intEnable &&
      (next_s.txDone || next_s.rxDone);
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Reset loads package values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s <= '{rxEnable: CONTROL_RESET[CTL_RX_ENABLE],
             multiproc: CONTROL_RESET[CTL_MULTIPROC],
             txNinth: CONTROL_RESET[CTL_TX_NINTH],
             rxNinth: CONTROL_RESET[CTL_RX_NINTH],
             txDone: CONTROL_RESET[CTL_TX_DONE],
             rxDone: CONTROL_RESET[CTL_RX_DONE],
             intEnable: STATUS_RESET[STA_INT_ENABLE],
             baudDouble: STATUS_RESET[STA_BAUD_DOUBLE],
             rxBuffer: RX_BUFFER_RESET,
             slaveAddr: SLAVE_ADDR_RESET,
             slaveMask: SLAVE_MASK_RESET,
             txData: 8'h00,
             txStart: 1'b0,
             divCnt: 2'h0,
             tick: 1'b0,
             rxdMeta: 1'b1,
             rxdSync: 1'b1,
             rdata: 32'h0000_0000,
             ready: 1'b0,
             slverr: 1'b0,
             irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  assign prdata = s.rdata;
  assign pready = s.ready;
  assign pslverr = s.slverr;

  assign txd = txLine;
  assign intReq = s.irq;

endmodule

`default_nettype wire

// ==== nine_bit_uart_monitor.sv ====
// Port-level checker of the nine-bit serial port
`timescale 1ns/1ps
`default_nettype none

module nine_bit_uart_monitor
  import nine_bit_uart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic txd,
  input wire logic intReq
);
  // ------
  // Helpers
  // ------
  logic setup; // Setup cycle
  logic wrAcc; // Write taking effect
  logic wrData; // Write into the data buffer
  logic mapped; // Address hits a register
  logic [10:0] hiRun; // Cycles txd high
  logic [10:0] loRun; // Cycles txd low
  assign setup = psel && !penable;
  assign wrAcc = psel && penable && pready && pwrite;
  assign wrData = wrAcc && (paddr == OFF_DATA);
  assign mapped = paddr inside {OFF_CONTROL, OFF_DATA, OFF_STATUS,
    OFF_SLAVE_ADDR, OFF_SLAVE_MASK};

  // Saturating run lengths of the transmit line
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hiRun <= 11'h000;
      loRun <= 11'h000;
    end else begin
      hiRun <= txd ? hiRun + {10'h000, hiRun != 11'h7FF} : 11'h000;
      loRun <= txd ? 11'h000 : loRun + {10'h000, loRun != 11'h7FF};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------
  // Assertions
  // ------
  property p_ready; setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_ready_place;
    pready |-> psel && penable && $past(setup);
  endproperty
  a_ready_place: assert property (p_ready_place)
    else $error("ready outside first access cycle");
  property p_err_map; pready && !mapped |-> pslverr; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_err_only; pslverr |-> pready && !mapped; endproperty
  a_err_only: assert property (p_err_only) else $error("stray slave error");
  property p_rdata_idle; !pready |-> prdata == 32'h0000_0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("data off access");
  property p_rdata_upper; pready |-> prdata[31:8] == 24'h000000; endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper bits set");
  property p_tx_starts; wrData && hiRun > 11'h2C0 |-> ##[1:3] !txd; endproperty
  a_tx_starts: assert property (p_tx_starts)
    else $error("idle write did not start a frame");
  property p_start_len; $rose(txd) |-> loRun >= 11'h020; endproperty
  a_start_len: assert property (p_start_len)
    else $error("low run shorter than a bit time");
  property p_int_drop; $fell(intReq) |-> $past(wrAcc); endproperty
  a_int_drop: assert property (p_int_drop)
    else $error("interrupt fell without a write");
endmodule

bind nine_bit_uart nine_bit_uart_monitor mon_u (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rxd(rxd), .txd(txd), .intReq(intReq));
`default_nettype wire

// ==== uart_remote_node.sv ====
// Remote serial node on the far end of the line
`timescale 1ns/1ps
`default_nettype none

module uart_remote_node (
  input wire logic clk,
  input wire logic lineIn, // Port transmit pin
  input wire logic fast, // Short bit time
  output logic lineOut, // Port receive pin
  output logic [8:0] gotWord, // Last frame heard
  output int gotCnt // Frames heard
);
  logic busy = 1'b0; // Sender active
  logic [9:0] bits; // Received slots
  int bitClks; // Clocks per bit
  assign bitClks = fast ? 32 : 64;
  initial lineOut = 1'b1; // Idle high
  initial gotCnt = 0;

  // Send start, byte LSB first, ninth, stop
  task automatic sendFrame(input logic [8:0] w);
    logic [10:0] f;
    int n;
    f = {1'b1, w, 1'b0};
    n = 0;
    while (busy && n < 2000) begin
      n++;
      @(posedge clk);
    end
    busy = 1'b1;
    for (int b = 0; b < 11; b++) begin
      lineOut <= f[b];
      repeat (bitClks) @(posedge clk);
    end
    busy = 1'b0;
  endtask

  // Hear frames, sampling each bit at its centre
  always begin
    @(negedge lineIn);
    repeat (bitClks / 2) @(posedge clk);
    for (int b = 0; b < 10; b++) begin
      repeat (bitClks) @(posedge clk);
      bits[b] = lineIn;
    end
    gotWord = bits[8:0];
    gotCnt = gotCnt + 1;
  end
endmodule
`default_nettype wire

// ==== nine_bit_uart_test.sv ====
// Self-checking bench of the nine-bit serial port
`timescale 1ns/1ps
`default_nettype none

module nine_bit_uart_test;
  import nine_bit_uart_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, rxd, txd, intReq;
  logic fast = 1'b0; // Partner bit time
  logic [31:0] seed = 32'h57D79EF0; // Random state
  logic [31:0] q; // Last read data
  logic err; // Last slave error
  logic [8:0] gotWord; // Frame heard by partner
  int gotCnt; // Frames heard by partner
  int mismatches = 0;
  int numChecks = 0;

  nine_bit_uart dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
    .txd(txd), .intReq(intReq));
  uart_remote_node node_u (.clk(clk), .lineIn(txd), .fast(fast),
    .lineOut(rxd), .gotWord(gotWord), .gotCnt(gotCnt));

  always #4 clk = ~clk;

  // ------
  // Helpers
  // ------
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Whether a frame is taken into the receive buffer
  function automatic logic accept(input logic [7:0] ctl,
    input logic [8:0] w, input logic [7:0] own, input logic [7:0] msk);
    if (!ctl[CTL_RX_ENABLE] || ctl[CTL_RX_DONE]) return 1'b0;
    if (!ctl[CTL_MULTIPROC]) return 1'b1;
    return w[8] && ((w[7:0] & msk) == (own & msk));
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error land in q and err
  task automatic apb(input logic wrt, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wrt;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Read control until a bit is set
  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_CONTROL, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 400);
    if (q[b] !== 1'b1) begin
      mismatches++;
      summarize();
    end
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    summarize();
  end

  // ------
  // Main sequence
  // ------
  initial begin
    logic [7:0] ctlTab [5];
    logic [8:0] wTab [5];
    logic [7:0] bufExp;
    logic ninExp, doneExp;
    logic [8:0] w;
    int cnt, n;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, then one unmapped word
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(q, 32'h0000_0000);
      check({31'h0, err}, {31'h0, i == 5});
    end
    apb(1'b1, 8'h14, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    apb(1'b1, OFF_SLAVE_ADDR, {seed[31:8], 8'h5A});
    apb(1'b1, OFF_SLAVE_MASK, 32'h0000_00F0);
    apb(1'b0, OFF_SLAVE_ADDR, 32'h0);
    check(q, 32'h0000_005A);
    // Acceptance cases at the short bit time, interrupt off
    fast <= 1'b1;
    apb(1'b1, OFF_STATUS, 32'(1) << STA_BAUD_DOUBLE);
    ctlTab = '{8'h00, 8'h30, 8'h30, 8'h30, 8'h11};
    wTab = '{9'h03C, 9'h05A, 9'h16A, 9'h153, 9'h111};
    bufExp = 8'h00;
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFF_CONTROL, {24'h0, ctlTab[i]});
      ninExp = ctlTab[i][CTL_RX_NINTH];
      doneExp = ctlTab[i][CTL_RX_DONE];
      if (accept(ctlTab[i], wTab[i], 8'h5A, 8'hF0)) begin
        bufExp = wTab[i][7:0];
        ninExp = wTab[i][8];
        doneExp = 1'b1;
      end
      node_u.sendFrame(wTab[i]);
      apb(1'b0, OFF_DATA, 32'h0);
      check(q, {24'h0, bufExp});
      apb(1'b0, OFF_CONTROL, 32'h0);
      check({30'h0, q[CTL_RX_NINTH], q[CTL_RX_DONE]},
        {30'h0, ninExp, doneExp});
      check({31'h0, intReq}, 32'h0);
    end
    // Overlapping transmit and receive at both rates
    for (int k = 0; k < 4; k++) begin
      fast <= k[0];
      apb(1'b1, OFF_STATUS, (32'(k[0]) << STA_BAUD_DOUBLE) | 32'h1);
      apb(1'b1, OFF_CONTROL, 32'h10 | (32'(k[1]) << CTL_TX_NINTH));
      seed = xorshift(seed);
      w = {k[1], seed[7:0]};
      cnt = gotCnt;
      fork
        node_u.sendFrame(seed[16:8]);
      join_none
      apb(1'b1, OFF_DATA, seed);
      poll(CTL_TX_DONE);
      check(32'(gotCnt), 32'(cnt));
      check({31'h0, intReq}, 32'h1);
      poll(CTL_RX_DONE);
      n = 0;
      while (gotCnt == cnt && n < 2000) begin
        n++;
        @(posedge clk);
      end
      check({23'h0, gotWord}, {23'h0, w});
      apb(1'b0, OFF_DATA, 32'h0);
      check(q, {24'h0, seed[15:8]});
      apb(1'b0, OFF_CONTROL, 32'h0);
      check({31'h0, q[CTL_RX_NINTH]}, {31'h0, seed[16]});
      apb(1'b1, OFF_CONTROL, 32'h10);
      repeat (64) @(posedge clk);
      check({31'h0, intReq}, 32'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
